// *** src/dssc_map.vh ***
`ifndef DSSC_MAP_VH
`define DSSC_MAP_VH
// Register addresses (8-bit register address byte after the device address)
`define DSSC_DEV_ADDR       7'h50
`define DSSC_REG_DIVMODE    8'h02
`define DSSC_REG_CFG        8'h03
`define DSSC_REG_OUTEN      8'h01
// Field positions, register 0x02
`define DSSC_DIV_A_LSB      0
`define DSSC_DIV_B_LSB      2
`define DSSC_MODE_A_LSB     4
`define DSSC_MODE_B_LSB     6
// Field positions, register 0x03
`define DSSC_CHOP_LSB       0
`define DSSC_SENSOR_BIT     2
`define DSSC_MON_PAIR_BIT   3
`define DSSC_MON_POS_BIT    4
// Field positions, output enable and counter clear bits
`define DSSC_OUTEN_BIT      7
`define DSSC_CLEAR_BIT      6
// Reset values
`define DSSC_RST_BYTE       8'h00
// Excitation modes
`define DSSC_MODE_MICRO     2'h0
`define DSSC_MODE_HALF      2'h1
`define DSSC_MODE_HALF_FT   2'h2
`define DSSC_MODE_FULL      2'h3
// Position counter: 1024 micro steps per electrical cycle (256 per quarter)
`define DSSC_POS_W          10
`define DSSC_POS_INIT       10'h000
`define DSSC_POS_MICRO_INC  10'h001
`define DSSC_POS_HALF_INC   10'h080
`define DSSC_POS_FULL_INC   10'h100
`define DSSC_POS_FULL_INIT  10'h380
`define DSSC_POS_HALF_MASK  10'h07f
// Bit counter values
`define DSSC_BIT_LAST       4'h7
`define DSSC_BIT_ACK        4'h8
`endif

// *** src/dssc_seq_pair.v ***
`timescale 1ns/100ps
`include "dssc_map.vh"
// One pair: step prescaler and excitation position counter
module dssc_seq_pair
(
  clk_sys,
  rst,
  step_rise,
  activate,
  div_sel,
  mode_sel,
  counter_clear,
  position,
  step_taken
);
  input                         clk_sys;
  input                         rst;
  input                         step_rise;
  input                         activate;
  input      [1:0]              div_sel;
  input      [1:0]              mode_sel;
  input                         counter_clear;
  output reg [`DSSC_POS_W-1:0]  position;
  output reg                    step_taken;

  reg [2:0]             div_cnt_r;
  reg [2:0]             div_mask;
  reg [`DSSC_POS_W-1:0] init_pos;
  reg [`DSSC_POS_W-1:0] pos_nxt;

  // Prescale mask for 1, 1/2, 1/4, 1/8
  always @*
  begin
    case (div_sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  // Initial position per mode
  always @*
  begin
    if (mode_sel == `DSSC_MODE_FULL)
      init_pos = `DSSC_POS_FULL_INIT;  // see RULE5
    else
      init_pos = `DSSC_POS_INIT;       // see RULE5
  end

  // Next position, stepping in the mode latched at this pulse
  always @*
  begin
    case (mode_sel)  // see RULE14
      `DSSC_MODE_MICRO:
        pos_nxt = position + `DSSC_POS_MICRO_INC;  // see RULE7
      `DSSC_MODE_HALF, `DSSC_MODE_HALF_FT:
        pos_nxt = (position & ~`DSSC_POS_HALF_MASK) + `DSSC_POS_HALF_INC;
      default:
        pos_nxt = (position & ~`DSSC_POS_HALF_MASK)
                  + ((position[7] == 1'b1) ? `DSSC_POS_FULL_INC : `DSSC_POS_HALF_INC);
    endcase
  end

  // Sequencer: prescale, advance, clear
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_r  <= 3'h0;
      position   <= `DSSC_POS_INIT;
      step_taken <= 1'b0;
    end
    else
    begin
      step_taken <= 1'b0;
      if (!activate || counter_clear)
      begin
        div_cnt_r <= 3'h0;
        position  <= init_pos;           // see RULE15
      end
      else if (step_rise)                // see RULE4
      begin
        if ((div_cnt_r & div_mask) == div_mask)  // see RULE8
        begin
          div_cnt_r  <= 3'h0;
          position   <= pos_nxt;         // see RULE16
          step_taken <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end
endmodule // dssc_seq_pair

// *** src/dssc_top.v ***
// Operation
// RULE1: Bridge on only when activated and enabled
// RULE2: Settings accepted while activate pin low
// RULE3: Supply loss resets settings, output off
// RULE4: Step rising edge advances; else held
// RULE5: Initial position per mode at reset
// RULE6: Two-bit mode code per pair
// RULE7: Micro-step gives 256 steps per quarter
// RULE8: Step prescale by 1, 2, 4, 8
// RULE9: Chopping frequency from second register
// RULE10: Sensor drive bit D2 of second register
// RULE11: Monitor low at selected pair position
// RULE12: Non-micro modes monitor initial position only
// RULE13: Monitor low from reaching edge to next
// RULE14: Mode change latched, used next step
// RULE15: Activate low: outputs off, position initial
// RULE16: Sequencer advances while output disabled
`timescale 1ns/100ps
`include "dssc_map.vh"
module dssc_top
(
  clk_sys,
  rst,
  chip_activate_input,
  step_pulse_pair_a,
  step_pulse_pair_b,
  scl_in,
  sda_in,
  sda_out,
  sda_oe_n,
  bridge_on,
  position_a,
  position_b,
  chop_sel,
  sensor_drive_on,
  position_monitor_out
);
  input                         clk_sys;
  input                         rst;
  input                         chip_activate_input;
  input                         step_pulse_pair_a;
  input                         step_pulse_pair_b;
  input                         scl_in;
  input                         sda_in;
  output reg                    sda_out;
  output reg                    sda_oe_n;
  output reg                    bridge_on;
  output reg [`DSSC_POS_W-1:0]  position_a;
  output reg [`DSSC_POS_W-1:0]  position_b;
  output reg [1:0]              chop_sel;
  output reg                    sensor_drive_on;
  output reg                    position_monitor_out;

  // Bus state machine
  localparam ST_IDLE = 2'h0;
  localparam ST_DEV  = 2'h1;
  localparam ST_REG  = 2'h2;
  localparam ST_DATA = 2'h3;

  reg [2:0]  ena_s_r;
  reg [2:0]  stpa_s_r;
  reg [2:0]  stpb_s_r;
  reg [2:0]  scl_s_r;
  reg [2:0]  sda_s_r;
  reg        ena_r;
  reg        stpa_r;
  reg        stpb_r;
  reg        scl_r;
  reg        sda_r;
  reg [1:0]  st_r;
  reg [3:0]  bit_r;
  reg [7:0]  shift_r;
  reg [7:0]  regaddr_r;
  reg        ack_r;
  reg        drop_r;
  reg [7:0]  divmode_r;
  reg [7:0]  cfg_r;
  reg        outen_r;
  reg        clear_r;
  reg        clear_dly_r;
  reg        mon_low_r;

  wire                   scl_rise;
  wire                   scl_fall;
  wire                   start_cond;
  wire                   stop_cond;
  wire                   stpa_rise;
  wire                   stpb_rise;
  wire [7:0]             byte_in;
  wire [`DSSC_POS_W-1:0] pos_a;
  wire [`DSSC_POS_W-1:0] pos_b;
  wire                   taken_a;
  wire                   taken_b;
  wire                   mon_pair;
  wire [1:0]             mon_mode;
  wire [`DSSC_POS_W-1:0] mon_pos;
  wire                   mon_taken;
  wire                   mon_hit;

  // Three-stage synchronisers on pins
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ena_s_r  <= 3'h0;
      stpa_s_r <= 3'h0;
      stpb_s_r <= 3'h0;
      scl_s_r  <= 3'h7;
      sda_s_r  <= 3'h7;
    end
    else
    begin
      ena_s_r  <= {ena_s_r[1:0], chip_activate_input};
      stpa_s_r <= {stpa_s_r[1:0], step_pulse_pair_a};
      stpb_s_r <= {stpb_s_r[1:0], step_pulse_pair_b};
      scl_s_r  <= {scl_s_r[1:0], scl_in};
      sda_s_r  <= {sda_s_r[1:0], sda_in};
    end
  end

  // Filtered levels change when stages two and three agree
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ena_r  <= 1'b0;
      stpa_r <= 1'b0;
      stpb_r <= 1'b0;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
    end
    else
    begin
      if (ena_s_r[1] == ena_s_r[2])
        ena_r <= ena_s_r[2];
      if (stpa_s_r[1] == stpa_s_r[2])
        stpa_r <= stpa_s_r[2];
      if (stpb_s_r[1] == stpb_s_r[2])
        stpb_r <= stpb_s_r[2];
      if (scl_s_r[1] == scl_s_r[2])
        scl_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2])
        sda_r <= sda_s_r[2];
    end
  end

  // Edge and bus condition decode
  assign scl_rise   = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_r;
  assign scl_fall   = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_r;
  assign start_cond = scl_r && (sda_s_r[1] == sda_s_r[2]) && !sda_s_r[2] && sda_r;
  assign stop_cond  = scl_r && (sda_s_r[1] == sda_s_r[2]) && sda_s_r[2] && !sda_r;
  assign stpa_rise  = (stpa_s_r[1] == stpa_s_r[2]) && stpa_s_r[2] && !stpa_r;
  assign stpb_rise  = (stpb_s_r[1] == stpb_s_r[2]) && stpb_s_r[2] && !stpb_r;
  assign byte_in    = {shift_r[6:0], sda_r};

  // Write-only serial slave; settings taken at 8th clock rise
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r      <= ST_IDLE;
      bit_r     <= 4'h0;
      shift_r   <= `DSSC_RST_BYTE;
      regaddr_r <= `DSSC_RST_BYTE;
      ack_r     <= 1'b0;
      drop_r    <= 1'b0;
      divmode_r <= `DSSC_RST_BYTE;  // see RULE3
      cfg_r     <= `DSSC_RST_BYTE;  // see RULE3
      outen_r   <= 1'b0;            // see RULE3
      clear_r   <= 1'b0;
    end
    else
    begin
      clear_r <= 1'b0;
      if (start_cond)
      begin
        st_r   <= ST_DEV;
        bit_r  <= 4'h0;
        ack_r  <= 1'b0;
        drop_r <= 1'b0;
      end
      else if (stop_cond)
      begin
        st_r  <= ST_IDLE;
        ack_r <= 1'b0;
      end
      else if (st_r != ST_IDLE && scl_rise && bit_r <= `DSSC_BIT_LAST)
      begin
        shift_r <= byte_in;
        if (bit_r == `DSSC_BIT_LAST)
        begin
          // Settings land here regardless of activate pin, see RULE2
          if (st_r == ST_DEV)
            drop_r <= (byte_in[7:1] != `DSSC_DEV_ADDR) || byte_in[0];
          else if (st_r == ST_REG)
            regaddr_r <= byte_in;
          else if (!drop_r)
          begin
            if (regaddr_r == `DSSC_REG_DIVMODE)
              divmode_r <= byte_in;             // see RULE6
            else if (regaddr_r == `DSSC_REG_CFG)
              cfg_r <= byte_in;                 // see RULE9
            else if (regaddr_r == `DSSC_REG_OUTEN)
            begin
              outen_r <= byte_in[`DSSC_OUTEN_BIT];  // see RULE16
              clear_r <= byte_in[`DSSC_CLEAR_BIT];  // see RULE5
            end
          end
        end
        bit_r <= bit_r + 4'h1;
      end
      else if (st_r != ST_IDLE && scl_fall)
      begin
        if (bit_r == `DSSC_BIT_ACK && !ack_r)
          ack_r <= !drop_r;
        else if (bit_r == `DSSC_BIT_ACK)
        begin
          ack_r <= 1'b0;
          bit_r <= 4'h0;
          if (st_r == ST_DEV)
            st_r <= drop_r ? ST_IDLE : ST_REG;
          else if (st_r == ST_REG)
            st_r <= ST_DATA;
        end
      end
    end
  end

  dssc_seq_pair u_pair_a
  (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .step_rise     (stpa_rise),
    .activate      (ena_r),
    .div_sel       (divmode_r[`DSSC_DIV_A_LSB+1:`DSSC_DIV_A_LSB]),    // see RULE8
    .mode_sel      (divmode_r[`DSSC_MODE_A_LSB+1:`DSSC_MODE_A_LSB]),  // see RULE6
    .counter_clear (clear_r),
    .position      (pos_a),
    .step_taken    (taken_a)
  );

  dssc_seq_pair u_pair_b
  (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .step_rise     (stpb_rise),
    .activate      (ena_r),
    .div_sel       (divmode_r[`DSSC_DIV_B_LSB+1:`DSSC_DIV_B_LSB]),
    .mode_sel      (divmode_r[`DSSC_MODE_B_LSB+1:`DSSC_MODE_B_LSB]),
    .counter_clear (clear_r),
    .position      (pos_b),
    .step_taken    (taken_b)
  );

  // Monitor selection
  assign mon_pair  = cfg_r[`DSSC_MON_PAIR_BIT];
  assign mon_mode  = mon_pair ? divmode_r[`DSSC_MODE_B_LSB+1:`DSSC_MODE_B_LSB]
                              : divmode_r[`DSSC_MODE_A_LSB+1:`DSSC_MODE_A_LSB];
  assign mon_pos   = mon_pair ? pos_b : pos_a;
  assign mon_taken = mon_pair ? taken_b : taken_a;
  assign mon_hit   = (cfg_r[`DSSC_MON_POS_BIT] && mon_mode == `DSSC_MODE_MICRO)
                     ? ((mon_pos & `DSSC_POS_HALF_MASK) == `DSSC_POS_INIT)  // see RULE11
                     : (mon_pos == `DSSC_POS_INIT
                        || (mon_mode == `DSSC_MODE_FULL
                            && mon_pos == `DSSC_POS_FULL_INIT));            // see RULE12

  // Monitor low held from reaching edge to next step edge
  // Counter clear looked at one cycle late, once positions are initial
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clear_dly_r <= 1'b0;
      mon_low_r   <= 1'b1;
    end
    else
    begin
      clear_dly_r <= clear_r;
      if (mon_taken || !ena_r || clear_dly_r)
        mon_low_r <= mon_hit;  // see RULE13
    end
  end

  // Registered outputs
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bridge_on            <= 1'b0;
      position_a           <= `DSSC_POS_INIT;
      position_b           <= `DSSC_POS_INIT;
      chop_sel             <= 2'h0;
      sensor_drive_on      <= 1'b0;
      position_monitor_out <= 1'b1;
      sda_out              <= 1'b1;
      sda_oe_n             <= 1'b1;
    end
    else
    begin
      bridge_on            <= ena_r && outen_r;                        // see RULE1
      position_a           <= pos_a;
      position_b           <= pos_b;
      chop_sel             <= cfg_r[`DSSC_CHOP_LSB+1:`DSSC_CHOP_LSB];  // see RULE9
      sensor_drive_on      <= cfg_r[`DSSC_SENSOR_BIT];                 // see RULE10
      position_monitor_out <= !mon_low_r;                              // see RULE11
      sda_out              <= 1'b0;
      sda_oe_n             <= !ack_r;
    end
  end
endmodule // dssc_top

// *** sim/dssc_host_model.sv ***
`timescale 1ns/100ps
// Host side: serial bus master and step pulse source
module dssc_host_model
(
  input  logic clk_sys,
  input  logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic step_a,
  output logic step_b
);
  // Bus released high, clock still, step pins low
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    {step_b, step_a} = 2'b00;
  end

  // Wait n falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One bit, 64 ns period; line sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = sda_line;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic bytex(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // Start, device address, register, data, stop
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat, output logic ok);
    logic a0, a1, a2;
    sda_drv = 1'b0;
    wt(8);
    scl = 1'b0;
    wt(4);
    bytex(8'ha0, a0);
    bytex(adr, a1);
    bytex(dat, a2);
    sda_drv = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_drv = 1'b1;
    wt(8);
    ok = a0 & a1 & a2;
  endtask

  // Step pulses on the pins in m, 16 cycles high, 12 low
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n)
    begin
      {step_b, step_a} = m;
      wt(16);
      {step_b, step_a} = 2'b00;
      wt(12);
    end
  endtask
endmodule // dssc_host_model

// *** sim/dssc_chk.sv ***
`timescale 1ns/100ps
// Port-level checks of the sequencer top
module dssc_chk
(
  input logic       clk_sys,
  input logic       rst,
  input logic       chip_activate_input,
  input logic       step_pulse_pair_a,
  input logic       step_pulse_pair_b,
  input logic       scl_in,
  input logic       sda_in,
  input logic       sda_out,
  input logic       sda_oe_n,
  input logic       bridge_on,
  input logic [9:0] position_a,
  input logic [9:0] position_b,
  input logic [1:0] chop_sel,
  input logic       sensor_drive_on,
  input logic       position_monitor_out
);
  logic [4:0] quiet_r;

  default clocking dflt @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Cycles with step pin A, bus clock and activate all high
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      quiet_r <= 5'h00;
    else if (step_pulse_pair_a && scl_in && chip_activate_input)
      quiet_r <= (quiet_r == 5'h1f) ? quiet_r : quiet_r + 5'h01;
    else
      quiet_r <= 5'h00;

  // Checks
  a_bridge_off_idle: assert property (!chip_activate_input [*6] |-> !bridge_on)
    else $error("bridge on while inactive");
  a_standby_pos_init: assert property (!chip_activate_input [*8] |->
    (position_a == 10'h000 || position_a == 10'h380)) else $error("standby position moved");
  a_pos_held: assert property (quiet_r > 5'd12 |-> $stable(position_a))
    else $error("position moved without step");
  a_mon_at_step: assert property ($fell(position_monitor_out) |->
    (position_a[6:0] == 7'h00 || position_b[6:0] == 7'h00)) else $error("monitor misplaced");
  a_reset_clears_all: assert property ($fell(rst) |-> !bridge_on && chop_sel == 2'h0 &&
    !sensor_drive_on && position_monitor_out) else $error("settings not cleared");
  a_ack_clock_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("ack began with clock high");
  a_ack_bounded: assert property ($fell(sda_oe_n) |-> ##[8:24] sda_oe_n)
    else $error("ack held too long");
  a_cfg_on_clock: assert property (!$stable(chop_sel) || !$stable(sensor_drive_on) |->
    scl_in) else $error("setting changed off clock");

  // Main scenarios
  c_ack: cover property ($fell(sda_oe_n));
  c_mon: cover property ($fell(position_monitor_out));
  c_bridge: cover property ($rose(bridge_on));
endmodule // dssc_chk

bind dssc_top dssc_chk chk
(
  .clk_sys(clk_sys), .rst(rst), .chip_activate_input(chip_activate_input),
  .step_pulse_pair_a(step_pulse_pair_a), .step_pulse_pair_b(step_pulse_pair_b),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .bridge_on(bridge_on), .position_a(position_a), .position_b(position_b),
  .chop_sel(chop_sel), .sensor_drive_on(sensor_drive_on),
  .position_monitor_out(position_monitor_out)
);

// *** sim/dssc_top_tb.sv ***
`timescale 1ns/100ps
// Self-checking bench of the sequencer top
module dssc_top_tb;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       chip_activate_input = 1'b0;
  logic       scl, sda_drv, step_a, step_b, sda_out, sda_oe_n, bridge_on, sensor_drive_on;
  logic       position_monitor_out, ok;
  logic [9:0] position_a, position_b;
  logic [1:0] chop_sel;
  int         compares = 0;
  int         miscompares = 0;
  // Open-drain data line with pull-up
  wire        sda_line = sda_drv & (sda_oe_n | sda_out);

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  dssc_top uut
  (
    .clk_sys(clk_sys), .rst(rst), .chip_activate_input(chip_activate_input),
    .step_pulse_pair_a(step_a), .step_pulse_pair_b(step_b), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bridge_on(bridge_on),
    .position_a(position_a), .position_b(position_b), .chop_sel(chop_sel),
    .sensor_drive_on(sensor_drive_on), .position_monitor_out(position_monitor_out)
  );
  dssc_host_model host
  (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
    .step_a(step_a), .step_b(step_b)
  );

  // Compare and count
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cb(input logic g, input logic e);
    chk({9'h0, g}, {9'h0, e});
  endtask

  // Verdict and end of run
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Setting write, every byte acknowledged
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    cb(ok, 1'b1);
  endtask

  // Activate pin, then let the synchroniser settle
  task automatic activ(input logic v);
    chip_activate_input = v;
    host.wt(10);
  endtask

  // Values after reset; monitor low at initial position
  task automatic t_reset;
    cb(bridge_on, 1'b0);
    chk({8'h0, chop_sel}, 10'h000);
    cb(sensor_drive_on, 1'b0);
    cb(position_monitor_out, 1'b0);
    chk(position_a, 10'h000);
  endtask

  // All chop and sensor codes, activate low; unmapped register ignored
  task automatic t_cfg;
    for (int c = 0; c < 8; c++)
    begin
      put(8'h03, 8'(c));
      chk({8'h0, chop_sel}, 10'(c & 3));
      cb(sensor_drive_on, c[2]);
    end
    put(8'h05, 8'h00);
    chk({8'h0, chop_sel}, 10'h003);
  endtask

  // Bridge gating, stepping while disabled, standby
  task automatic t_bridge;
    put(8'h01, 8'h80);
    cb(bridge_on, 1'b0);
    activ(1'b1);
    cb(bridge_on, 1'b1);
    put(8'h01, 8'h00);
    cb(bridge_on, 1'b0);
    host.pulse(2'b01, 3);
    chk(position_a, 10'h003);
    put(8'h01, 8'h80);
    cb(bridge_on, 1'b1);
    chk(position_a, 10'h003);
    activ(1'b0);
    chk(position_a, 10'h000);
    host.pulse(2'b01, 2);
    chk(position_a, 10'h000);
    activ(1'b1);
  endtask

  // Prescaler codes on both pairs
  task automatic t_div;
    logic [9:0] pa, pb;
    for (int d = 0; d < 4; d++)
    begin
      put(8'h02, 8'(d * 5));
      pa = position_a;
      pb = position_b;
      host.pulse(2'b11, 8);
      chk(position_a - pa, 10'(8 >> d));
      chk(position_b - pb, 10'(8 >> d));
    end
  endtask

  // Initial position and one step per excitation mode
  task automatic t_mode;
    logic [9:0] ini [4] = '{10'h000, 10'h000, 10'h000, 10'h380};
    logic [9:0] stp [4] = '{10'h001, 10'h080, 10'h080, 10'h080};
    for (int m = 0; m < 4; m++)
    begin
      put(8'h02, 8'(m * 'h50));
      host.pulse(2'b11, 1);
      put(8'h01, 8'hc0);
      chk(position_a, ini[m]);
      chk(position_b, ini[m]);
      host.pulse(2'b11, 1);
      chk(position_a, stp[m]);
      chk(position_b, stp[m]);
    end
  endtask

  // Monitor at 1-2 phase positions in micro-step, then in 1-2 phase mode
  task automatic t_mon;
    put(8'h02, 8'h00);
    host.pulse(2'b01, 1);
    put(8'h03, 8'h10);
    put(8'h01, 8'hc0);
    host.pulse(2'b01, 127);
    cb(position_monitor_out, 1'b1);
    host.pulse(2'b01, 1);
    cb(position_monitor_out, 1'b0);
    host.pulse(2'b10, 2);
    cb(position_monitor_out, 1'b0);
    host.pulse(2'b01, 1);
    cb(position_monitor_out, 1'b1);
    put(8'h02, 8'h50);
    host.pulse(2'b01, 1);
    put(8'h01, 8'hc0);
    cb(position_monitor_out, 1'b0);
    for (int i = 1; i <= 8; i++)
    begin
      host.pulse(2'b01, 1);
      cb(position_monitor_out, i != 8);
    end
    put(8'h03, 8'h08);
    host.pulse(2'b10, 7);
    cb(position_monitor_out, 1'b1);
    host.pulse(2'b10, 1);
    cb(position_monitor_out, 1'b0);
  endtask

  // Mid-run supply loss
  task automatic t_supply;
    put(8'h03, 8'h07);
    rst = 1'b1;
    host.wt(2);
    rst = 1'b0;
    host.wt(10);
    t_reset();
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    host.wt(10);
    t_reset();
    t_cfg();
    t_bridge();
    t_div();
    t_mode();
    t_mon();
    t_supply();
    conclude();
  end

  // Watchdog, about five times the expected run
  initial
  begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule // dssc_top_tb
